//--- verilog/cfg_defs.svh
// Configuration word layout, protection codes and reset-support timing
`ifndef CFG_DEFS_SVH
`define CFG_DEFS_SVH

`define CFG_WORD_W           14
`define PROG_ADDR_W          11
`define CFG_ADDR             14'h2007
`define CFG_SPACE_LO         14'h2000
`define CFG_SPACE_HI         14'h3fff
`define CFG_ERASED           14'h3fff

`define CFG_PROT_A_MSB       13
`define CFG_PROT_B_MSB       11
`define CFG_DATA_PROT_N_BIT  8
`define CFG_LOW_V_PROG_BIT   7
`define CFG_BROWNOUT_BIT     6
`define CFG_EXT_RESET_BIT    5
`define CFG_OSC_SEL2_BIT     4
`define CFG_POWERUP_N_BIT    3
`define CFG_WATCHDOG_BIT     2
`define CFG_OSC_SEL1_BIT     1
`define CFG_OSC_SEL0_BIT     0

`define PROT_NONE            2'h3
`define PROT_UPPER           2'h2
`define PROT_MID             2'h1
`define PROT_ALL             2'h0
`define PROT_BASE_UPPER      11'h400
`define PROT_BASE_MID        11'h200
`define PROT_BASE_ALL        11'h000
`define PROG_TOP             11'h7ff

`define OSC_CRYSTAL_MAX      3'h2

`define CLK_MHZ              125
`define POWERUP_US           72000
`define POWERUP_CYCLES       (`POWERUP_US * `CLK_MHZ)
`define BROWNOUT_US          72000
`define BROWNOUT_CYCLES      (`BROWNOUT_US * `CLK_MHZ)
`define SETTLE_CYCLES        1024
`define WATCHDOG_TICKS       18

`define TMR_POWERUP          0
`define TMR_SETTLE           1
`define TMR_BROWNOUT         2
`define TMR_COUNT            3

`endif

//--- verilog/cfg_pkg.sv
// Types shared by the configuration and reset-support logic
`include "cfg_defs.svh"
package cfg_pkg;
    typedef logic [`CFG_WORD_W-1:0]  cfg_word_t;
    typedef logic [`PROG_ADDR_W-1:0] prog_addr_t;
    typedef logic [1:0]              prot_code_t;
    typedef logic [2:0]              osc_sel_t;
    typedef enum logic [4:0] {
        ST_POWERUP = 5'h01,
        ST_SETTLE  = 5'h02,
        ST_RUN     = 5'h04,
        ST_SLEEP   = 5'h08,
        ST_HOLD    = 5'h10
    } phase_e;
endpackage

//--- verilog/timer_if.sv
// Start and busy pair between the sequencer and a hold timer
`timescale 1ns/1ps
interface timer_if;
    logic start;
    logic busy;
    modport timer (input start, output busy);
    modport user  (output start, input busy);
endinterface

//--- verilog/hold_timer.sv
// Retriggerable down-counter that reports busy for CYCLES cycles after start
`timescale 1ns/1ps
module hold_timer #(
    parameter int CYCLES = 1024
) (
    input  wire logic    clock,
    input  wire logic    reset,
    timer_if.timer       tif
);
    localparam int W = $clog2(CYCLES + 1);

    logic [W-1:0] cnt_q;

    // Restart on every start so a lingering cause keeps stretching the hold
    always_ff @(posedge clock) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (tif.start) begin
            cnt_q <= W'(CYCLES);
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign tif.busy = (cnt_q != '0);

    property p_timer_start;
        @(posedge clock) disable iff (reset)
        tif.start |=> tif.busy && cnt_q == W'(CYCLES);
    endproperty
    a_timer_start: assert property (p_timer_start)
        else $error("hold timer did not load on start");
endmodule

//--- verilog/config_word_reset_support.sv
// Configuration word store, option decode and reset/sleep sequencing
// Overview of operation
// [R1] A programmed configuration bit reads 0, an unprogrammed bit reads 1.
// [R2] The configuration word lives at program address 2007h.
// [R3] Config space 2000h-3FFFh is reachable only in programming mode.
// [R4] Word is 14 bits; two copies of the protection field select the range.
// [R5] Protection 11 none, 10 0400h-07FFh, 01 0200h-07FFh, 00 0000h-07FFh.
// [R6] Bit 8 at 1 leaves data memory open, at 0 protects it.
// [R7] Watchdog enabled by configuration, counted on its own RC tick.
// [R8] Settle timer holds reset until the crystal oscillator is stable.
// [R9] Power-up timer holds reset 72 ms, only after power-up; a hold cause in ST_POWERUP goes to ST_HOLD, which skips the rest.
// [R10] Brown-out resets the device for at least 72 ms.
// [R11] Sleep ends on external reset, watchdog wake-up or enabled interrupt.
// [R12] Word is latched during reset and held stable while running.
`timescale 1ns/1ps
`include "cfg_defs.svh"
module config_word_reset_support #(
    parameter int POWERUP_CYCLES  = `POWERUP_CYCLES,
    parameter int BROWNOUT_CYCLES = `BROWNOUT_CYCLES,
    parameter int SETTLE_CYCLES   = `SETTLE_CYCLES,
    parameter int WATCHDOG_TICKS  = `WATCHDOG_TICKS
) (
    input  wire logic               clock,
    input  wire logic               reset,
    input  wire logic               prog_mode,
    input  wire cfg_pkg::cfg_word_t prog_addr,
    input  wire logic               prog_write,
    input  wire logic               prog_read,
    input  wire cfg_pkg::cfg_word_t prog_wdata,
    output logic                    prog_rvalid,
    output cfg_pkg::cfg_word_t      prog_rdata,
    input  wire cfg_pkg::prog_addr_t check_addr,
    output logic                    check_protected,
    output logic                    code_protect_on,
    output cfg_pkg::prog_addr_t     protect_base,
    output logic                    data_protect_on,
    output logic                    low_voltage_prog_enable,
    output logic                    brownout_enable,
    output logic                    ext_reset_pin_enable,
    output logic                    powerup_delay_enable,
    output logic                    watchdog_enable,
    output cfg_pkg::osc_sel_t       osc_select,
    input  wire logic               brownout_detect,
    input  wire logic               ext_reset_n,
    input  wire logic               watchdog_rc_tick,
    input  wire logic               watchdog_clear,
    input  wire logic               sleep_request,
    input  wire logic               irq_wake,
    output logic                    device_reset,
    output logic                    sleeping,
    output logic                    watchdog_expired,
    output logic                    wake_event
);
    import cfg_pkg::*;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    localparam int TIMER_CYCLES [`TMR_COUNT] = '{POWERUP_CYCLES, SETTLE_CYCLES,
                                                 BROWNOUT_CYCLES};
    localparam int WD_W = $clog2(WATCHDOG_TICKS + 1);

    // Non-volatile cell: survives reset, only the programmer alters it
    cfg_word_t          nv_word_q = `CFG_ERASED;
    cfg_word_t          cfg_q;
    phase_e             phase_q;
    logic               por_start_q;
    logic               settle_start_q;
    logic [WD_W-1:0]    wd_cnt_q;
    logic               wd_fire;
    logic               crystal;
    logic               ext_reset_active;
    logic               hold_cause;
    logic               prog_access_ok;
    prot_code_t         prot_code;
    int unsigned        powerup_cnt_q;

    timer_if tmr [`TMR_COUNT] ();

    function automatic logic in_cfg_space(input cfg_word_t addr);
        in_cfg_space = (addr >= `CFG_SPACE_LO) && (addr <= `CFG_SPACE_HI);
    endfunction

    function automatic prog_addr_t prot_base(input prot_code_t code);
        case (code)
            `PROT_UPPER: prot_base = `PROT_BASE_UPPER;
            `PROT_MID:   prot_base = `PROT_BASE_MID;
            `PROT_ALL:   prot_base = `PROT_BASE_ALL;
            `PROT_NONE:  prot_base = `PROG_TOP;
        endcase
    endfunction

    // Programmer side of the configuration space
    assign prog_access_ok = prog_mode && in_cfg_space(prog_addr); // [R3]

    always_ff @(posedge clock) begin
        if (prog_access_ok && prog_write && prog_addr == `CFG_ADDR) begin // [R2]
            nv_word_q <= prog_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            prog_rvalid <= 1'b0;
            prog_rdata  <= '0;
        end else begin
            prog_rvalid <= prog_access_ok && prog_read; // [R3]
            if (prog_access_ok && prog_read) begin
                prog_rdata <= (prog_addr == `CFG_ADDR) ? nv_word_q : `CFG_ERASED; // [R2]
            end
        end
    end

    // Options only change across a reset, so running logic never sees a glitch
    always_ff @(posedge clock) begin
        if (reset) begin
            cfg_q <= nv_word_q; // [R12]
        end
    end

    // A copy that says protect wins over one that does not
    assign prot_code = cfg_q[`CFG_PROT_A_MSB -: 2] & cfg_q[`CFG_PROT_B_MSB -: 2]; // [R4]
    assign code_protect_on         = (prot_code != `PROT_NONE); // [R1]
    assign protect_base            = prot_base(prot_code); // [R5]
    assign data_protect_on         = !cfg_q[`CFG_DATA_PROT_N_BIT]; // [R6]
    assign low_voltage_prog_enable = cfg_q[`CFG_LOW_V_PROG_BIT];
    assign brownout_enable         = cfg_q[`CFG_BROWNOUT_BIT];
    assign ext_reset_pin_enable    = cfg_q[`CFG_EXT_RESET_BIT];
    assign powerup_delay_enable    = !cfg_q[`CFG_POWERUP_N_BIT]; // [R1]
    assign watchdog_enable         = cfg_q[`CFG_WATCHDOG_BIT]; // [R7]
    assign osc_select = {cfg_q[`CFG_OSC_SEL2_BIT], cfg_q[`CFG_OSC_SEL1_BIT],
                         cfg_q[`CFG_OSC_SEL0_BIT]};

    // Upper bound is implicit: the address cannot exceed the top of memory
    always_ff @(posedge clock) begin
        if (reset) begin
            check_protected <= 1'b0;
        end else begin
            check_protected <= code_protect_on && check_addr >= prot_base(prot_code); // [R5]
        end
    end

    // Reset hold timers
    assign crystal          = (osc_select <= `OSC_CRYSTAL_MAX);
    assign ext_reset_active = ext_reset_pin_enable && !ext_reset_n;
    assign hold_cause       = ext_reset_active || (brownout_enable && brownout_detect) ||
                              tmr[`TMR_BROWNOUT].busy;

    assign tmr[`TMR_POWERUP].start  = por_start_q && powerup_delay_enable; // [R9]
    assign tmr[`TMR_SETTLE].start   = settle_start_q; // [R8]
    assign tmr[`TMR_BROWNOUT].start = brownout_enable && brownout_detect; // [R10]

    for (genvar i = 0; i < `TMR_COUNT; i++) begin : g_timer
        hold_timer #(
            .CYCLES (TIMER_CYCLES[i])
        ) u_timer (
            .clock  (clock),
            .reset  (reset),
            .tif    (tmr[i])
        );
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            por_start_q <= 1'b1;
        end else begin
            por_start_q <= 1'b0;
        end
    end

    // Phase sequencer
    always_ff @(posedge clock) begin
        if (reset) begin
            phase_q        <= ST_POWERUP;
            settle_start_q <= 1'b0;
            wake_event     <= 1'b0;
        end else begin
            settle_start_q <= 1'b0;
            wake_event     <= 1'b0;
            unique case (phase_q)
                ST_POWERUP: begin
                    if (hold_cause) begin
                        phase_q <= ST_HOLD;
                    end else if (!por_start_q && !tmr[`TMR_POWERUP].busy) begin // [R9]
                        phase_q        <= ST_SETTLE;
                        settle_start_q <= crystal;
                    end
                end
                ST_SETTLE: begin
                    if (hold_cause) begin
                        phase_q <= ST_HOLD;
                    end else if (!settle_start_q && !tmr[`TMR_SETTLE].busy) begin // [R8]
                        phase_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (hold_cause || wd_fire) begin
                        phase_q <= ST_HOLD;
                    end else if (sleep_request) begin
                        phase_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (hold_cause) begin // [R11]
                        phase_q    <= ST_HOLD;
                        wake_event <= 1'b1;
                    end else if (wd_fire || irq_wake) begin // [R11]
                        phase_q        <= ST_SETTLE;
                        settle_start_q <= crystal;
                        wake_event     <= 1'b1;
                    end
                end
                ST_HOLD: begin
                    // Later resets skip the power-up delay
                    if (!hold_cause) begin // [R9] [R10]
                        phase_q        <= ST_SETTLE;
                        settle_start_q <= crystal;
                    end
                end
            endcase
        end
    end

    assign device_reset = (phase_q == ST_POWERUP) || (phase_q == ST_SETTLE) ||
                          (phase_q == ST_HOLD);
    assign sleeping     = (phase_q == ST_SLEEP);

    // Watchdog counts ticks of its own RC source, not the system clock
    assign wd_fire = watchdog_enable && watchdog_rc_tick &&
                     wd_cnt_q == WD_W'(WATCHDOG_TICKS - 1); // [R7]

    always_ff @(posedge clock) begin
        if (reset) begin
            wd_cnt_q <= '0;
        end else if (!watchdog_enable || watchdog_clear || device_reset ||
                     (phase_q == ST_RUN && sleep_request)) begin // [R7]
            wd_cnt_q <= '0;
        end else if (watchdog_rc_tick) begin
            wd_cnt_q <= wd_fire ? '0 : wd_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            watchdog_expired <= 1'b0;
        end else begin
            watchdog_expired <= wd_fire;
        end
    end

    // Checking helpers
    always_ff @(posedge clock) begin
        if (reset) begin
            powerup_cnt_q <= 0;
        end else if (phase_q == ST_POWERUP) begin
            powerup_cnt_q <= powerup_cnt_q + 1;
        end
    end

    property p_cfg_write_lands;
        prog_mode && prog_write && prog_addr == `CFG_ADDR |=> nv_word_q == $past(prog_wdata);
    endproperty
    a_cfg_write_lands: assert property (p_cfg_write_lands) // [R2]
        else $error("config word write not stored");

    property p_cfg_locked;
        !prog_mode |=> nv_word_q == $past(nv_word_q) && !prog_rvalid;
    endproperty
    a_cfg_locked: assert property (p_cfg_locked) // [R3]
        else $error("config space reached outside programming mode");

    property p_opts_stable;
        !$past(reset) |-> $stable(cfg_q) && $stable(protect_base);
    endproperty
    a_opts_stable: assert property (p_opts_stable) // [R12]
        else $error("options changed while running");

    property p_copies_combine;
        cfg_q[`CFG_PROT_A_MSB -: 2] == `PROT_NONE && cfg_q[`CFG_PROT_B_MSB -: 2] == `PROT_ALL
        |-> code_protect_on && protect_base == `PROT_BASE_ALL;
    endproperty
    a_copies_combine: assert property (p_copies_combine) // [R4]
        else $error("protection copies not combined");

    property p_protect_mid;
        prot_code == `PROT_MID && check_addr >= `PROT_BASE_MID |=> check_protected;
    endproperty
    a_protect_mid: assert property (p_protect_mid) // [R5]
        else $error("0200h range not protected");

    property p_protect_none;
        prot_code == `PROT_NONE |=> !check_protected;
    endproperty
    a_protect_none: assert property (p_protect_none) // [R5]
        else $error("protection reported while off");

    property p_data_protect;
        (data_protect_on == !cfg_q[`CFG_DATA_PROT_N_BIT]) and
        (cfg_q == `CFG_ERASED |-> !data_protect_on);
    endproperty
    a_data_protect: assert property (p_data_protect) // [R6]
        else $error("data protection polarity wrong");

    property p_watchdog_off;
        !watchdog_enable |=> wd_cnt_q == '0 && !watchdog_expired;
    endproperty
    a_watchdog_off: assert property (p_watchdog_off) // [R7]
        else $error("watchdog counted while disabled");

    property p_settle_hold;
        phase_q == ST_SETTLE && tmr[`TMR_SETTLE].busy |=> phase_q != ST_RUN && device_reset;
    endproperty
    a_settle_hold: assert property (p_settle_hold) // [R8]
        else $error("released before oscillator settled");

    property p_powerup_len;
        $past(phase_q) == ST_POWERUP && phase_q == ST_SETTLE && powerup_delay_enable
        |-> powerup_cnt_q >= POWERUP_CYCLES + 1;
    endproperty
    a_powerup_len: assert property (p_powerup_len) // [R9]
        else $error("power-up hold too short");

    property p_no_powerup_again;
        phase_q != ST_POWERUP |=> phase_q != ST_POWERUP;
    endproperty
    a_no_powerup_again: assert property (p_no_powerup_again) // [R9]
        else $error("power-up delay after a later reset");

    property p_brownout_hold;
        brownout_enable && $fell(brownout_detect) |-> device_reset [*8];
    endproperty
    a_brownout_hold: assert property (p_brownout_hold) // [R10]
        else $error("brown-out reset not stretched");

    property p_wake_irq;
        sleeping && irq_wake && !hold_cause |=> !sleeping && wake_event;
    endproperty
    a_wake_irq: assert property (p_wake_irq) // [R11]
        else $error("interrupt did not wake");

    property p_wake_ext;
        sleeping && ext_reset_active |=> device_reset && wake_event;
    endproperty
    a_wake_ext: assert property (p_wake_ext) // [R11]
        else $error("external reset did not wake");

    c_reach_run:       cover property (phase_q == ST_SETTLE ##1 phase_q == ST_RUN);
    c_sleep_irq_wake:  cover property (sleeping && irq_wake ##1 wake_event && !sleeping);
    c_watchdog_reset:  cover property (phase_q == ST_RUN && wd_fire);
    c_brownout:        cover property (brownout_enable && brownout_detect && !device_reset);
endmodule

//--- dv/prog_model.sv
// Behavioural device programmer driving the configuration port
`timescale 1ns/1ps
module prog_model (
    input  wire logic          clock,
    output logic               prog_mode,
    output cfg_pkg::cfg_word_t prog_addr,
    output logic               prog_write,
    output logic               prog_read,
    output cfg_pkg::cfg_word_t prog_wdata
);
    import cfg_pkg::*;
    initial begin
        prog_mode  = 1'b0;
        prog_addr  = 14'h0000;
        prog_write = 1'b0;
        prog_read  = 1'b0;
        prog_wdata = 14'h0000;
    end
    // One access per call; mode is raised only around it
    task automatic access(input logic mode, input cfg_word_t addr, input logic wr,
                          input cfg_word_t data);
        @(posedge clock);
        prog_mode  <= mode;
        prog_addr  <= addr;
        prog_write <= wr;
        prog_read  <= !wr;
        prog_wdata <= data;
        @(posedge clock);
        prog_mode  <= 1'b0;
        prog_write <= 1'b0;
        prog_read  <= 1'b0;
        // Released lines show the inverse, so a stale address or word never looks valid
        prog_addr  <= ~addr;
        prog_wdata <= ~data;
    endtask
endmodule

//--- dv/tb.sv
// Self-checking bench for configuration decode and reset sequencing
`timescale 1ns/1ps
module tb;
    import cfg_pkg::*;
    localparam int PU = 40;
    localparam int BO = 12;
    localparam int ST = 10;
    localparam int WT = 4;
    localparam logic [4:0] SLP = 5'h01;
    localparam logic [4:0] IRQ = 5'h02;
    localparam logic [4:0] TCK = 5'h04;
    localparam logic [4:0] CLR = 5'h08;
    localparam logic [4:0] EXT = 5'h10;
    logic       clock, reset, brownout_detect;
    logic [4:0] strobe;
    logic       prog_mode, prog_write, prog_read, prog_rvalid;
    cfg_word_t  prog_addr, prog_wdata, prog_rdata;
    prog_addr_t check_addr, protect_base;
    osc_sel_t   osc_select;
    logic       check_protected, code_protect_on, data_protect_on;
    logic       low_voltage_prog_enable, brownout_enable, ext_reset_pin_enable;
    logic       powerup_delay_enable, watchdog_enable;
    logic       device_reset, sleeping, watchdog_expired, wake_event;
    int         errors = 0;
    int         n_compared = 0;
    cfg_word_t  exp_q[$];

    config_word_reset_support #(.POWERUP_CYCLES(PU), .BROWNOUT_CYCLES(BO),
        .SETTLE_CYCLES(ST), .WATCHDOG_TICKS(WT)) DUT (
        .clock(clock), .reset(reset), .prog_mode(prog_mode), .prog_addr(prog_addr),
        .prog_write(prog_write), .prog_read(prog_read), .prog_wdata(prog_wdata),
        .prog_rvalid(prog_rvalid), .prog_rdata(prog_rdata), .check_addr(check_addr),
        .check_protected(check_protected), .code_protect_on(code_protect_on),
        .protect_base(protect_base), .data_protect_on(data_protect_on),
        .low_voltage_prog_enable(low_voltage_prog_enable),
        .brownout_enable(brownout_enable), .ext_reset_pin_enable(ext_reset_pin_enable),
        .powerup_delay_enable(powerup_delay_enable), .watchdog_enable(watchdog_enable),
        .osc_select(osc_select), .brownout_detect(brownout_detect),
        .ext_reset_n(!strobe[4]), .watchdog_rc_tick(strobe[2]),
        .watchdog_clear(strobe[3]), .sleep_request(strobe[0]), .irq_wake(strobe[1]),
        .device_reset(device_reset), .sleeping(sleeping),
        .watchdog_expired(watchdog_expired), .wake_event(wake_event));

    prog_model prog (.clock(clock), .prog_mode(prog_mode), .prog_addr(prog_addr),
        .prog_write(prog_write), .prog_read(prog_read), .prog_wdata(prog_wdata));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // A read answer with nothing noted is itself a mismatch
    always @(negedge clock) begin
        if (prog_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("prog_rvalid", 16'h1, 16'h0);
            end else begin
                chk("prog_rdata", prog_rdata, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        conclude();
    end

    task automatic wr(input cfg_word_t a, input cfg_word_t d);
        prog.access(1'b1, a, 1'b1, d);
    endtask

    task automatic rd(input cfg_word_t a, input cfg_word_t e);
        exp_q.push_back(e);
        prog.access(1'b1, a, 1'b0, 14'h0000);
    endtask

    task automatic do_reset();
        @(posedge clock) reset <= 1'b1;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        #1;
    endtask

    task automatic pulse(input logic [4:0] m);
        @(posedge clock) strobe <= m;
        @(posedge clock) strobe <= 5'h00;
        #1;
    endtask

    task automatic wait_run(output int n);
        n = 0;
        while (device_reset !== 1'b0 && n < 2000) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("left reset", 16'(n < 2000), 16'h1);
    endtask

    task automatic opts(input cfg_word_t w, input prog_addr_t base);
        chk("protect_base", protect_base, base);
        chk("code_protect_on", code_protect_on, base != 11'h7ff);
        chk("data_protect_on", data_protect_on, !w[8]);
        chk("options", {low_voltage_prog_enable, brownout_enable, ext_reset_pin_enable,
            powerup_delay_enable, watchdog_enable, osc_select},
            {w[7], w[6], w[5], !w[3], w[2], w[4], w[1], w[0]});
    endtask

    initial begin
        int         n;
        cfg_word_t  w;
        prog_addr_t a;
        prog_addr_t prev;
        static prot_code_t pa[5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3};
        static prot_code_t pb[5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h0};
        static prog_addr_t bs[5] = '{11'h7ff, 11'h400, 11'h200, 11'h000, 11'h000};
        reset = 1'b1;
        strobe = 5'h00;
        brownout_detect = 1'b0;
        check_addr = 11'h000;
        void'($urandom(90796));
        do_reset();
        opts(14'h3fff, 11'h7ff);
        wait_run(n);
        // Wrong mode, outside config space, or another config address
        prog.access(1'b0, 14'h2007, 1'b1, 14'h0000);
        prog.access(1'b1, 14'h1007, 1'b1, 14'h0000);
        wr(14'h2006, 14'h0000);
        prog.access(1'b0, 14'h2007, 1'b0, 14'h0000);
        prog.access(1'b1, 14'h0007, 1'b0, 14'h0000);
        rd(14'h2006, 14'h3fff);
        rd(14'h2007, 14'h3fff);
        $display("test access done");
        prev = 11'h7ff;
        for (int i = 0; i < 5; i++) begin
            w = {pa[i], pb[i], 1'b1, 9'($urandom) | 9'h008};
            wr(14'h2007, w);
            rd(14'h2007, w);
            chk("held base", protect_base, prev);
            do_reset();
            opts(w, bs[i]);
            for (int j = 0; j < 4; j++) begin
                a = (j == 0) ? bs[i] : (j == 1) ? bs[i] - 11'h1 : (j == 2) ? 11'h7ff
                    : 11'($urandom);
                @(posedge clock) check_addr <= a;
                @(posedge clock);
                #1;
                chk("check_protected", check_protected, bs[i] != 11'h7ff && a >= bs[i]);
            end
            prev = bs[i];
            wait_run(n);
        end
        $display("test protection done");
        // Crystal mode, power-up delay on, watchdog, brown-out, pin reset on
        wr(14'h2007, 14'h3fe4);
        do_reset();
        wait_run(n);
        chk("powerup hold", 16'(n >= PU + ST), 16'h1);
        pulse(SLP);
        chk("sleeping", sleeping, 1'b1);
        pulse(EXT);
        chk("ext wake", {sleeping, device_reset}, 2'b01);
        wait_run(n);
        chk("settle only", 16'(n >= ST && n < PU), 16'h1);
        pulse(IRQ);
        chk("irq in run", {sleeping, wake_event}, 2'b00);
        pulse(SLP);
        pulse(IRQ);
        chk("irq wake", {sleeping, wake_event}, 2'b01);
        wait_run(n);
        $display("test sleep done");
        repeat (WT - 1) pulse(TCK);
        pulse(CLR);
        repeat (WT - 1) pulse(TCK);
        chk("cleared", device_reset, 1'b0);
        pulse(TCK);
        chk("wd reset", {device_reset, watchdog_expired}, 2'b11);
        wait_run(n);
        pulse(SLP);
        repeat (WT) pulse(TCK);
        chk("wd wake", {sleeping, wake_event, watchdog_expired}, 3'b011);
        wait_run(n);
        $display("test watchdog done");
        @(posedge clock) brownout_detect <= 1'b1;
        @(posedge clock);
        #1;
        chk("brownout", device_reset, 1'b1);
        repeat (2) @(posedge clock);
        @(posedge clock) brownout_detect <= 1'b0;
        #1;
        wait_run(n);
        chk("brownout hold", 16'(n >= BO && n < BO + PU + ST), 16'h1);
        $display("test brownout done");
        chk("reads left", 16'(exp_q.size()), 16'h0);
        conclude();
    end
endmodule
